// file: core/exc_pkg.sv
// Functional notes
// - hardware interrupts taken after instruction completes; return to next instruction
// - faults serviced before offending instruction; traps reported right after it
// - fault return address is first byte of instruction including prefixes
// - aborts need not be precise and are not restartable
// - 256 vectors of 8-byte entries; 0-31 reserved, 224 for system
// - get vector, read gate, then push return address and flags; return restores
// - exceptions vector internally; maskable vector comes from acknowledge cycle
// - maskable taken only when request high, enable flag set, at boundary or string-move window
// - string moves open an interrupt window between individual moves
// - interrupt gate clears enable; trap keeps; task loads it; return restores
// - non-maskable request uses vector 2 without acknowledge cycle
// - non-maskable blocked until return or reset; one further request latched
// - table entry 2 gate type decides maskable blocking during non-maskable
// - software interrupt n uses vector n; breakpoint uses 3; exception class
// - non-maskable first at shared boundary, then maskable if still enabled
// - exception checks repeat each instruction, overlapped with execution
// - fault state kept so every faulting instruction can restart
// - exception while entering handler for vectors 10-13 raises double fault 8
// - vector table: faults 0,5,6,7,10-13,16; trap 4; aborts 8,9
// - debug vector 1 may report previous trap and next fault together
// - order: debug trap, non-maskable, maskable, debug fault, decode/segment faults
package exc_pkg;
   localparam int unsigned VEC_W         = 8;
   localparam int unsigned ADDR_W        = 32;
   localparam int unsigned ENTRY_BYTES   = 8;
   localparam int unsigned DESC_SHIFT    = 3;
   localparam logic [7:0]  VEC_DIVIDE    = 8'h00;
   localparam logic [7:0]  VEC_DEBUG     = 8'h01;
   localparam logic [7:0]  VEC_NMI       = 8'h02;
   localparam logic [7:0]  VEC_BREAK     = 8'h03;
   localparam logic [7:0]  VEC_OVERFLOW  = 8'h04;
   localparam logic [7:0]  VEC_DOUBLE    = 8'h08;
   localparam logic [7:0]  VEC_SEG_OVR   = 8'h09;
   localparam logic [7:0]  VEC_SEG_LO    = 8'h0A;
   localparam logic [7:0]  VEC_SEG_HI    = 8'h0D;
   localparam logic [7:0]  VEC_SYS_FIRST = 8'h20;

   typedef enum logic [1:0] {GATE_MASKABLE_IRQ_IN, GATE_TRAP, GATE_TASK} gate_t;
   typedef enum logic [1:0] {CLS_FAULT, CLS_TRAP, CLS_ABORT, CLS_MASKABLE_IRQ_IN} exc_class_t;

   // instruction-boundary view from the core
   typedef struct packed {
      logic              boundary;     // instruction retired
      logic              str_window;   // between string moves
      logic [ADDR_W-1:0] cur_addr;     // first byte incl. prefixes
      logic [ADDR_W-1:0] next_addr;
      logic              dbg_trap;
      logic              dbg_fault;
      logic              fault;        // decode/segment fault on next
      logic [VEC_W-1:0]  fault_vec;
      logic              trap;         // overflow trap of retired instr
      logic              soft_int;
      logic              soft_short;   // one-byte breakpoint form
      logic [VEC_W-1:0]  soft_vec;
   } core_evt_t;

   // entry request to the microcode sequencer
   typedef struct packed {
      logic              valid;
      logic [VEC_W-1:0]  vector;
      exc_class_t        cls;
      logic [ADDR_W-1:0] ret_addr;
      logic [ADDR_W-1:0] desc_addr;
      logic              restartable;
   } entry_t;
endpackage

// file: core/exc_classify.sv
`timescale 1ns/10ps
`default_nettype none
module exc_classify
   import exc_pkg::*;
(
   input  wire logic [VEC_W-1:0] vec_i,
   output exc_class_t            cls_o,
   output logic                  seg_o
);
   always_comb begin
      seg_o = (vec_i >= VEC_SEG_LO) && (vec_i <= VEC_SEG_HI);
      unique case (vec_i)
         VEC_OVERFLOW, VEC_BREAK, VEC_DEBUG: cls_o = CLS_TRAP;
         VEC_DOUBLE, VEC_SEG_OVR:            cls_o = CLS_ABORT;
         default:                            cls_o = CLS_FAULT;
      endcase
   end
endmodule // exc_classify
`default_nettype wire

// file: core/interrupt_exception_unit.sv
`timescale 1ns/10ps
`default_nettype none
module interrupt_exception_unit
   import exc_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              arst_n_i,
   input  wire core_evt_t         evt_i,
   input  wire logic              maskable_irq_in_i,
   input  wire logic              nmi_i,
   input  wire logic              ack_valid_i,
   input  wire logic [VEC_W-1:0]  ack_vec_i,
   input  wire logic [ADDR_W-1:0] table_base_i,
   input  wire gate_t             gate_i,
   input  wire logic              gate_valid_i,
   input  wire logic              task_if_i,
   input  wire logic              entry_exc_i,
   input  wire logic              entry_done_i,
   input  wire logic              interrupt_return_instr_i,
   input  wire logic              saved_if_i,
   input  wire logic              set_if_i,
   input  wire logic              clr_if_i,
   output logic                   ack_req_o,
   output entry_t                 entry_o,
   output logic                   push_o,
   output logic                   busy_o,
   output logic                   if_o,
   output logic                   nmi_active_o
);
   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   typedef enum logic [2:0] {S_RUN, S_ACK, S_GATE, S_ENTER} st_t;
   st_t st_q, st_d;
   entry_t ent_q, ent_d;
   logic if_q, if_d;
   logic nmi_act_q, nmi_act_d;
   logic nmi_pend_q, nmi_pend_d;
   logic nmi_prev_q, nmi_prev_d;
   logic nmi_blk_int_q, nmi_blk_int_d;
   logic in_seg_q, in_seg_d;
   logic in_nmi_q, in_nmi_d;
   logic nmi_req_q, nmi_req_d;   // edge not taken in the cycle it is seen, waiting

   exc_class_t cls_w;
   logic       seg_w;
   logic [VEC_W-1:0] pick_vec;
   logic       nmi_edge, nmi_take, take_point, int_ok;

   exc_classify u_cls (
      .vec_i (pick_vec),
      .cls_o (cls_w),
      .seg_o (seg_w)
   );

   // -------------------------------------------------------------
   // selection
   // -------------------------------------------------------------
   assign nmi_edge   = nmi_i & ~nmi_prev_q;
   assign nmi_take   = nmi_edge | nmi_req_q;
   assign take_point = evt_i.boundary | evt_i.str_window;
   assign int_ok     = maskable_irq_in_i & if_q & ~(nmi_act_q & nmi_blk_int_q);

   always_comb begin
      pick_vec = VEC_DIVIDE;
      if (evt_i.dbg_trap)                         pick_vec = VEC_DEBUG;
      else if (evt_i.trap)                        pick_vec = VEC_OVERFLOW;
      else if (evt_i.soft_int)                    pick_vec = evt_i.soft_short ? VEC_BREAK : evt_i.soft_vec;
      else if (evt_i.dbg_fault)                   pick_vec = VEC_DEBUG;
      else if (evt_i.fault)                       pick_vec = evt_i.fault_vec;
   end

   always_comb begin
      st_d          = st_q;
      ent_d         = ent_q;
      ent_d.valid   = 1'b0;
      if_d          = if_q;
      nmi_act_d     = nmi_act_q;
      nmi_pend_d    = nmi_pend_q | (nmi_edge & nmi_act_q);
      nmi_req_d     = nmi_req_q | (nmi_edge & ~nmi_act_q);
      nmi_prev_d    = nmi_i;
      nmi_blk_int_d = nmi_blk_int_q;
      in_seg_d      = in_seg_q;
      in_nmi_d      = in_nmi_q;
      if (set_if_i) if_d = 1'b1;
      if (clr_if_i) if_d = 1'b0;
      unique case (st_q)
         S_RUN: begin
            if (interrupt_return_instr_i) begin
               if_d = saved_if_i;
               if (nmi_act_q && nmi_pend_q) begin
                  nmi_pend_d = nmi_edge;   // an edge in this cycle stays latched
                  in_nmi_d   = 1'b1;
                  ent_d.vector = VEC_NMI;
                  ent_d.cls    = CLS_MASKABLE_IRQ_IN;
                  ent_d.ret_addr = evt_i.next_addr;
                  st_d = S_GATE;
               end else begin
                  nmi_act_d  = 1'b0;
                  nmi_pend_d = 1'b0;
                  nmi_req_d  = nmi_req_q | nmi_edge;
               end
            end else if (evt_i.boundary && (evt_i.dbg_trap || evt_i.trap || evt_i.soft_int)) begin
               ent_d.vector   = pick_vec;
               ent_d.cls      = CLS_TRAP;
               ent_d.ret_addr = evt_i.next_addr;
               in_nmi_d = 1'b0;
               st_d = S_GATE;
            end else if (take_point && nmi_take && !nmi_act_q) begin
               nmi_req_d      = 1'b0;
               ent_d.vector   = VEC_NMI;
               ent_d.cls      = CLS_MASKABLE_IRQ_IN;
               ent_d.ret_addr = evt_i.next_addr;
               nmi_act_d = 1'b1;
               in_nmi_d  = 1'b1;
               st_d = S_GATE;
            end else if (take_point && int_ok) begin
               ent_d.cls      = CLS_MASKABLE_IRQ_IN;
               ent_d.ret_addr = evt_i.next_addr;
               in_nmi_d = 1'b0;
               st_d = S_ACK;
            end else if (evt_i.boundary && (evt_i.dbg_fault || evt_i.fault)) begin
               ent_d.vector   = pick_vec;
               ent_d.cls      = cls_w;
               ent_d.ret_addr = evt_i.cur_addr;
               in_nmi_d = 1'b0;
               st_d = S_GATE;
            end
         end
         S_ACK: if (ack_valid_i) begin
            ent_d.vector = ack_vec_i;
            st_d = S_GATE;
         end
         S_GATE: begin
            ent_d.desc_addr = table_base_i
                            + {{(ADDR_W-VEC_W-DESC_SHIFT){1'b0}}, ent_q.vector, {DESC_SHIFT{1'b0}}};
            if (gate_valid_i) begin
               unique case (gate_i)
                  GATE_MASKABLE_IRQ_IN: if_d = 1'b0;
                  GATE_TRAP: if_d = if_q;
                  GATE_TASK: if_d = task_if_i;
                  default:   if_d = if_q;
               endcase
               if (in_nmi_q) nmi_blk_int_d = (gate_i == GATE_MASKABLE_IRQ_IN);
               st_d = S_ENTER;
            end
         end
         S_ENTER: begin
            if (entry_exc_i) begin
               if (in_seg_q) begin
                  ent_d.vector = VEC_DOUBLE;
                  ent_d.cls    = CLS_ABORT;
                  in_seg_d     = 1'b0;
               end else begin
                  // nested fault is reported as a protection fault, itself a segment class
                  ent_d.vector = VEC_SEG_HI;
                  ent_d.cls    = CLS_FAULT;
                  in_seg_d     = 1'b1;
               end
               st_d = S_GATE;
            end else if (entry_done_i) begin
               ent_d.valid = 1'b1;
               in_seg_d    = 1'b0;
               st_d = S_RUN;
            end
         end
         default: st_d = S_RUN;
      endcase
      if (st_q == S_RUN && st_d == S_GATE) in_seg_d = seg_w && (ent_d.cls == CLS_FAULT);
      ent_d.restartable = (ent_d.cls != CLS_ABORT);
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_q          <= S_RUN;
         ent_q         <= '0;
         if_q          <= 1'b0;
         nmi_act_q     <= 1'b0;
         nmi_pend_q    <= 1'b0;
         nmi_prev_q    <= 1'b0;
         nmi_blk_int_q <= 1'b1;
         in_seg_q      <= 1'b0;
         in_nmi_q      <= 1'b0;
         nmi_req_q     <= 1'b0;
      end else begin
         st_q          <= st_d;
         ent_q         <= ent_d;
         if_q          <= if_d;
         nmi_act_q     <= nmi_act_d;
         nmi_pend_q    <= nmi_pend_d;
         nmi_prev_q    <= nmi_prev_d;
         nmi_blk_int_q <= nmi_blk_int_d;
         in_seg_q      <= in_seg_d;
         in_nmi_q      <= in_nmi_d;
         nmi_req_q     <= nmi_req_d;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign ack_req_o    = (st_q == S_ACK);
   assign push_o       = (st_q == S_ENTER);
   assign busy_o       = (st_q != S_RUN);
   assign entry_o      = ent_q;
   assign if_o         = if_q;
   assign nmi_active_o = nmi_act_q;

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   a_nmi_vector: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_q == S_RUN && !interrupt_return_instr_i && take_point && nmi_take && !nmi_act_q
       && !(evt_i.boundary && (evt_i.dbg_trap || evt_i.trap || evt_i.soft_int)))
      |=> (st_q == S_GATE && ent_q.vector == VEC_NMI)) else $error("nmi vector wrong");
   a_nmi_no_ack: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_q == S_GATE && in_nmi_q) |-> !ack_req_o) else $error("ack during nmi");
   a_int_gate_if: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_q == S_GATE && gate_valid_i && gate_i == GATE_MASKABLE_IRQ_IN && !set_if_i) |=> !if_q)
      else $error("interrupt gate kept enable");
   a_trap_gate_if: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_q == S_GATE && gate_valid_i && gate_i == GATE_TRAP && !set_if_i && !clr_if_i) |=> if_q == $past(if_q))
      else $error("trap gate changed enable");
   a_task_gate_if: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_q == S_GATE && gate_valid_i && gate_i == GATE_TASK && !set_if_i && !clr_if_i) |=> if_q == $past(task_if_i))
      else $error("task gate enable wrong");
   a_return_if: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_q == S_RUN && interrupt_return_instr_i) |=> if_q == $past(saved_if_i))
      else $error("return did not restore enable");
   a_mask_needs_if: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_q == S_RUN ##1 st_q == S_ACK) |-> $past(if_q) && $past(maskable_irq_in_i))
      else $error("maskable taken while disabled");
   a_mask_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_q == S_RUN && !if_q) |=> st_q != S_ACK) else $error("maskable taken with enable clear");
   a_mask_point: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_q == S_RUN && !take_point) |=> st_q != S_ACK) else $error("maskable taken off boundary");
   a_str_window: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_q == S_RUN && !interrupt_return_instr_i && evt_i.str_window && !evt_i.boundary
       && int_ok && !nmi_take) |=> st_q == S_ACK) else $error("string window ignored");
   a_ack_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_q == S_ACK && !ack_valid_i) |=> st_q == S_ACK) else $error("acknowledge left early");
   a_ack_vector: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_q == S_ACK && ack_valid_i) |=> (st_q == S_GATE && ent_q.vector == $past(ack_vec_i)))
      else $error("acknowledge vector lost");
   a_trap_ret: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_q == S_RUN && !interrupt_return_instr_i && evt_i.boundary && (evt_i.dbg_trap || evt_i.trap || evt_i.soft_int))
      |=> (st_q == S_GATE && ent_q.cls == CLS_TRAP && ent_q.ret_addr == $past(evt_i.next_addr))) else $error("trap entry wrong");
   a_debug_first: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_q == S_RUN && !interrupt_return_instr_i && evt_i.boundary && evt_i.dbg_trap)
      |=> ent_q.vector == VEC_DEBUG) else $error("debug trap not first");
   a_fault_ret: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_q == S_GATE && ent_q.cls == CLS_FAULT && $past(st_q) == S_RUN) |-> ent_q.ret_addr == $past(evt_i.cur_addr))
      else $error("fault return address wrong");
   a_fault_restart: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (ent_q.valid && ent_q.cls == CLS_FAULT) |-> ent_q.restartable) else $error("fault not restartable");
   a_double_fault: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_q == S_ENTER && entry_exc_i && in_seg_q) |=> ent_q.vector == VEC_DOUBLE && ent_q.cls == CLS_ABORT)
      else $error("double fault missing");
   a_desc_addr: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_q == S_GATE) |=> ent_q.desc_addr == $past(table_base_i) + ENTRY_BYTES * $past(ent_q.vector))
      else $error("descriptor address wrong");
   a_gate_wait: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_q == S_GATE && !gate_valid_i) |=> st_q == S_GATE) else $error("gate read skipped");
   a_valid_pulse: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      ent_q.valid |=> !ent_q.valid) else $error("entry valid held");
   a_valid_source: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      ent_q.valid |-> $past(st_q) == S_ENTER && $past(entry_done_i)) else $error("entry valid without entry");
   a_nmi_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (nmi_act_q && !interrupt_return_instr_i) |=> nmi_act_q) else $error("nmi released without return");
   a_nmi_latch: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (nmi_act_q && nmi_edge) |=> (nmi_pend_q || nmi_req_q)) else $error("nested nmi lost");
   a_nmi_blocks: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_q == S_RUN && nmi_act_q && nmi_blk_int_q) |=> st_q != S_ACK) else $error("maskable during blocked nmi");
   a_abort_norst: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      ent_q.cls == CLS_ABORT |-> !ent_q.restartable) else $error("abort restartable");
   a_break_vec: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_q == S_RUN && !interrupt_return_instr_i && evt_i.boundary && evt_i.soft_int
       && evt_i.soft_short && !evt_i.dbg_trap && !evt_i.trap) |=> ent_q.vector == VEC_BREAK)
      else $error("breakpoint vector wrong");

   // -------------------------------------------------------------
   // coverage
   // -------------------------------------------------------------
   c_nmi: cover property (@(posedge clk_i) disable iff (!arst_n_i) st_q == S_GATE && in_nmi_q);
   c_window: cover property (@(posedge clk_i) disable iff (!arst_n_i)
      st_q == S_RUN && evt_i.str_window && !evt_i.boundary ##1 st_q == S_ACK);
   c_ack: cover property (@(posedge clk_i) disable iff (!arst_n_i) st_q == S_ACK ##1 st_q == S_GATE);
   c_dbl: cover property (@(posedge clk_i) disable iff (!arst_n_i) ent_q.vector == VEC_DOUBLE);
   c_pend: cover property (@(posedge clk_i) disable iff (!arst_n_i) nmi_pend_q && interrupt_return_instr_i);
endmodule // interrupt_exception_unit
`default_nettype wire

// file: verif/irq_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module irq_ctrl_model
   import exc_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             arst_n_i,
   input  wire logic             raise_i,
   input  wire logic [VEC_W-1:0] vec_i,
   input  wire logic [1:0]       delay_i,
   input  wire logic             ack_req_i,
   output logic                  irq_o,
   output logic                  ack_valid_o,
   output logic [VEC_W-1:0]      ack_vec_o
);
   logic [VEC_W-1:0] vec_q;
   logic [1:0]       cnt_q;
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_o       <= 1'b0;
         ack_valid_o <= 1'b0;
         ack_vec_o   <= 8'h00;
         vec_q       <= 8'h00;
         cnt_q       <= 2'h0;
      end else begin
         ack_valid_o <= 1'b0;
         ack_vec_o   <= ~ack_vec_o; // vector lines not held outside the answer
         if (raise_i) begin
            irq_o <= 1'b1;
            vec_q <= vec_i;
         end
         if (ack_req_i && !ack_valid_o) begin
            if (cnt_q == delay_i) begin
               ack_valid_o <= 1'b1;
               ack_vec_o   <= vec_q;
               irq_o       <= 1'b0; // request held until acknowledged
               cnt_q       <= 2'h0;
            end else begin
               cnt_q <= cnt_q + 2'h1;
            end
         end
      end
   end
endmodule // irq_ctrl_model
`default_nettype wire

// file: verif/interrupt_exception_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
module interrupt_exception_unit_tb;
   import exc_pkg::*;
   logic clk_i = 0, arst_n_i = 0, nmi_i = 0, gate_valid_i = 0, task_if_i = 0, entry_exc_i = 0, entry_done_i = 0;
   logic ret_i = 0, saved_if_i = 0, set_if_i = 0, clr_if_i = 0, raise = 0, irq, ack_valid, ack_req_o, push_o, busy_o;
   logic if_o, nmi_active_o, exp_if;
   logic [1:0] dly = 0;
   logic [7:0] rvec = 0, ack_vec;
   logic [31:0] table_base_i = 32'h0000_0000, seed = 32'h0000_0055;
   core_evt_t evt_i = '0;
   gate_t gate_i = GATE_MASKABLE_IRQ_IN;
   entry_t entry_o;
   int error_cnt = 0, n_tests = 0, cyc = 0, i;
   core_evt_t e;
   always #5 clk_i = ~clk_i;
   interrupt_exception_unit interrupt_exception_unit_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .evt_i(evt_i),
      .maskable_irq_in_i(irq), .nmi_i(nmi_i), .ack_valid_i(ack_valid), .ack_vec_i(ack_vec),
      .table_base_i(table_base_i), .gate_i(gate_i), .gate_valid_i(gate_valid_i), .task_if_i(task_if_i),
      .entry_exc_i(entry_exc_i), .entry_done_i(entry_done_i), .interrupt_return_instr_i(ret_i),
      .saved_if_i(saved_if_i), .set_if_i(set_if_i), .clr_if_i(clr_if_i), .ack_req_o(ack_req_o),
      .entry_o(entry_o), .push_o(push_o), .busy_o(busy_o), .if_o(if_o), .nmi_active_o(nmi_active_o));
   irq_ctrl_model irq_ctrl_model_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .raise_i(raise), .vec_i(rvec),
      .delay_i(dly), .ack_req_i(ack_req_o), .irq_o(irq), .ack_valid_o(ack_valid), .ack_vec_o(ack_vec));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic core_evt_t mk();
      core_evt_t r;
      r = '0;
      r.boundary = 1'b1;
      r.cur_addr = rnd();
      r.next_addr = r.cur_addr + 32'(rnd() % 15) + 32'h0000_0001;
      return r;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("tests %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic bnd(input core_evt_t ev, input logic rt);
      @(posedge clk_i);
      evt_i <= ev;
      ret_i <= rt;
      @(posedge clk_i);
      evt_i <= '0;
      ret_i <= 1'b0;
      #1;
   endtask
   task automatic pls(input int which);
      @(posedge clk_i);
      if (which == 0) set_if_i <= 1'b1; else clr_if_i <= 1'b1;
      @(posedge clk_i);
      set_if_i <= 1'b0;
      clr_if_i <= 1'b0;
      exp_if = (which == 0);
   endtask
   task automatic entry(input logic [7:0] v, input exc_class_t c, input logic [31:0] ra, input gate_t g, input int nexc);
      chk(32'(ack_req_o), 32'(c == CLS_MASKABLE_IRQ_IN && v != VEC_NMI), "ack cycle");
      for (int k = 0; k <= nexc; k++) begin
         for (i = 0; i < 40 && ack_req_o; i++) @(posedge clk_i) #1;
         @(posedge clk_i);
         gate_valid_i <= 1'b1;
         gate_i <= g;
         task_if_i <= 1'(rnd());
         @(posedge clk_i);
         gate_valid_i <= 1'b0;
         #1 chk(32'(push_o), 32'h1, "push");
         @(posedge clk_i);
         if (k < nexc) entry_exc_i <= 1'b1; else entry_done_i <= 1'b1;
         @(posedge clk_i);
         {entry_exc_i, entry_done_i} <= 2'b00;
         #1;
      end
      for (i = 0; i < 4 && !entry_o.valid; i++) @(posedge clk_i) #1;
      chk(32'(entry_o.valid), 32'h1, "entry valid");
      chk(32'(entry_o.vector), 32'(v), "vector");
      chk(32'(entry_o.cls), 32'(c), "class");
      chk(entry_o.desc_addr, table_base_i + 32'(v) * 32'h0000_0008, "descriptor");
      if (c != CLS_ABORT) chk(entry_o.ret_addr, ra, "return address");
      exp_if = (g == GATE_TRAP) ? exp_if : (g == GATE_TASK) ? task_if_i : 1'b0;
      chk(32'(if_o), 32'(exp_if), "enable flag");
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   always @(posedge clk_i) if (++cyc == 20000) begin error_cnt++; finish_test(); end
   initial begin
      logic [7:0] fv [9] = '{8'h00, 8'h05, 8'h06, 8'h07, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h10};
      repeat (16) @(posedge clk_i);
      arst_n_i <= 1'b1;
      table_base_i <= rnd();
      chk(32'(if_o), 32'h0, "reset flag");
      pls(0);
      foreach (fv[j]) begin
         e = mk(); e.fault = 1'b1; e.fault_vec = fv[j];
         bnd(e, 1'b0);
         entry(fv[j], CLS_FAULT, e.cur_addr, gate_t'(rnd() % 3), 0);
      end
      e = mk(); e.trap = 1'b1; bnd(e, 1'b0); entry(VEC_OVERFLOW, CLS_TRAP, e.next_addr, GATE_TRAP, 0);
      e = mk(); e.dbg_trap = 1'b1; e.dbg_fault = 1'b1; bnd(e, 1'b0);
      entry(VEC_DEBUG, CLS_TRAP, e.next_addr, GATE_TRAP, 0);
      for (int s = 0; s < 4; s++) begin
         e = mk(); e.soft_int = 1'b1; e.soft_short = s[0]; e.soft_vec = 8'(rnd());
         bnd(e, 1'b0);
         entry(s[0] ? VEC_BREAK : e.soft_vec, CLS_TRAP, e.next_addr, GATE_TRAP, 0);
      end
      for (int s = 0; s < 4; s++) begin
         pls(s == 3);
         rvec = 8'(VEC_SYS_FIRST + rnd() % 224);
         dly = 2'(rnd());
         @(posedge clk_i) raise <= 1'b1;
         @(posedge clk_i) raise <= 1'b0;
         e = mk(); e.boundary = (s != 1); e.str_window = (s == 1); bnd(e, 1'b0);
         if (s == 3) begin
            repeat (3) @(posedge clk_i) #1 chk(32'(busy_o | ack_req_o), 32'h0, "masked request");
            pls(0);
            e = mk(); bnd(e, 1'b0);
         end
         entry(rvec, CLS_MASKABLE_IRQ_IN, e.next_addr, GATE_MASKABLE_IRQ_IN, 0);
         saved_if_i <= 1'b1;
         e = mk(); bnd(e, 1'b1); @(posedge clk_i) #1 exp_if = 1'b1;
         chk(32'(if_o), 32'h1, "return restores flag");
      end
      rvec = 8'h41;
      @(posedge clk_i) begin raise <= 1'b1; nmi_i <= 1'b1; end
      @(posedge clk_i) raise <= 1'b0;
      e = mk(); bnd(e, 1'b0);
      entry(VEC_NMI, CLS_MASKABLE_IRQ_IN, e.next_addr, GATE_TRAP, 0);
      chk(32'(nmi_active_o), 32'h1, "nmi active");
      @(posedge clk_i) nmi_i <= 1'b0;
      @(posedge clk_i) nmi_i <= 1'b1;
      e = mk(); bnd(e, 1'b0);
      entry(rvec, CLS_MASKABLE_IRQ_IN, e.next_addr, GATE_MASKABLE_IRQ_IN, 0);
      exp_if = 1'b1;
      e = mk(); bnd(e, 1'b1);
      entry(VEC_NMI, CLS_MASKABLE_IRQ_IN, e.next_addr, GATE_TRAP, 0); // latched request served at the first return
      e = mk(); bnd(e, 1'b1);
      @(posedge clk_i) #1 chk(32'(nmi_active_o), 32'h0, "nmi released");
      e = mk(); e.fault = 1'b1; e.fault_vec = 8'(VEC_SEG_LO + rnd() % 4);
      bnd(e, 1'b0);
      entry(VEC_DOUBLE, CLS_ABORT, 32'h0000_0000, GATE_MASKABLE_IRQ_IN, 1);
      finish_test();
   end
endmodule // interrupt_exception_unit_tb
`default_nettype wire
